/* File: shared/frt_capture_pkg.sv */
// constants and carrier types for the free-running timer with capture
package frt_capture_pkg;
  localparam int          CLK_MHZ         = 250;
  localparam int          TICK_NS         = 1000;
  localparam int          CLK_PERIOD_NS   = 1000 / CLK_MHZ;
  localparam int          US_CYCLES       = TICK_NS / CLK_PERIOD_NS;
  localparam int          US_CNT_W        = 8;
  localparam logic [7:0]  US_LAST         = 8'(US_CYCLES - 1);
  localparam int          TIMER_W         = 16;
  localparam logic [15:0] TIMER_RST       = 16'h0000;
  localparam logic [15:0] TIMER_MAX       = 16'hFFFF;
  localparam int          PERIODIC_US     = 1024;
  localparam int          PERIODIC_BIT    = $clog2(PERIODIC_US);
  localparam logic [9:0]  PERIODIC_MASK   = 10'h3FF;
  localparam int          SLICE_W         = 8;
  localparam int          SLICE_SEL_W     = 4;
  localparam logic [7:0]  CAP_RST         = 8'h00;
  localparam logic [15:0] INTERVAL_RST    = 16'h0000;

  typedef struct packed {
    logic [SLICE_SEL_W-1:0] slice_sel_a;
    logic [SLICE_SEL_W-1:0] slice_sel_b;
    logic                   gang_en;
    logic                   rise_en_a;
    logic                   fall_en_a;
    logic                   rise_en_b;
    logic                   fall_en_b;
  } cap_cfg_t;

  typedef struct packed {
    logic [SLICE_W-1:0] rise_a;
    logic [SLICE_W-1:0] fall_a;
    logic [SLICE_W-1:0] rise_b;
    logic [SLICE_W-1:0] fall_b;
  } cap_vals_t;

  typedef struct packed {
    logic interval;
    logic periodic;
    logic wrap;
    logic capture_a;
    logic capture_b;
  } timer_irq_t;
endpackage

/* File: logic/frt_capture.sv */
// free-running 16-bit timer with interval, periodic, wrap and two capture channels
`timescale 1ns/1ps
module frt_capture (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         capture_input_a,
  input  wire logic                         capture_input_b,
  input  wire logic [15:0]                  interval,
  input  wire frt_capture_pkg::cap_cfg_t    cap_cfg,
  input  wire frt_capture_pkg::timer_irq_t  irq_mask,
  output logic      [15:0]                  timer_r,
  output frt_capture_pkg::cap_vals_t        cap_vals_r,
  output frt_capture_pkg::timer_irq_t       irq_r
);
  logic [7:0]  us_cnt_r;
  logic        us_tick;
  logic [15:0] timer_nxt;
  logic [15:0] interval_cnt_r;
  logic        in_a_r;
  logic        in_b_r;
  logic        rise_a;
  logic        fall_a;
  logic        rise_b;
  logic        fall_b;
  logic        save_a;
  logic        save_b;
  logic [7:0]  slice_a;
  logic [7:0]  slice_b;
  logic        ev_interval;
  logic        ev_periodic;
  logic        ev_wrap;

  // microsecond enable from the 250 MHz clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      us_cnt_r <= 8'h00;
    end else if (us_tick) begin
      us_cnt_r <= 8'h00;
    end else begin
      us_cnt_r <= us_cnt_r + 8'h01;
    end
  end
  assign us_tick = (us_cnt_r == frt_capture_pkg::US_LAST);

  assign timer_nxt = timer_r + 16'h0001;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer_r <= frt_capture_pkg::TIMER_RST;
    end else if (us_tick) begin
      timer_r <= timer_nxt;
    end
  end

  // interval counter reloads on its last count so the period is interval ticks
  // zero interval disables it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      interval_cnt_r <= frt_capture_pkg::INTERVAL_RST;
    end else if (us_tick) begin
      if (interval_cnt_r <= 16'h0001) begin
        interval_cnt_r <= interval;
      end else begin
        interval_cnt_r <= interval_cnt_r - 16'h0001;
      end
    end
  end
  assign ev_interval = us_tick && (interval != 16'h0000) && (interval_cnt_r == 16'h0001);
  assign ev_periodic = us_tick &&
    ((timer_nxt[frt_capture_pkg::PERIODIC_BIT-1:0] & frt_capture_pkg::PERIODIC_MASK) == 10'h000);
  assign ev_wrap = us_tick && (timer_r == frt_capture_pkg::TIMER_MAX);

  // inputs are synchronous; one stage for edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_a_r <= 1'b0;
      in_b_r <= 1'b0;
    end else begin
      in_a_r <= capture_input_a;
      in_b_r <= capture_input_b;
    end
  end
  assign rise_a = capture_input_a & ~in_a_r & cap_cfg.rise_en_a;
  assign fall_a = ~capture_input_a & in_a_r & cap_cfg.fall_en_a;
  assign rise_b = capture_input_b & ~in_b_r & cap_cfg.rise_en_b;
  assign fall_b = ~capture_input_b & in_b_r & cap_cfg.fall_en_b;

  // slice select picks timer bits [sel+7:sel]; ganged mode uses a's edge for both bytes
  always_comb begin
    slice_a = 8'(timer_r >> cap_cfg.slice_sel_a);
    slice_b = 8'(timer_r >> cap_cfg.slice_sel_b);
    if (cap_cfg.gang_en) begin
      slice_a = timer_r[7:0];
      slice_b = timer_r[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_vals_r <= {4{frt_capture_pkg::CAP_RST}};
    end else begin
      if (rise_a) begin
        cap_vals_r.rise_a <= slice_a;
      end
      if (fall_a) begin
        cap_vals_r.fall_a <= slice_a;
      end
      if (cap_cfg.gang_en ? rise_a : rise_b) begin
        cap_vals_r.rise_b <= slice_b;
      end
      if (cap_cfg.gang_en ? fall_a : fall_b) begin
        cap_vals_r.fall_b <= slice_b;
      end
    end
  end
  assign save_a = rise_a | fall_a;
  assign save_b = cap_cfg.gang_en ? 1'b0 : (rise_b | fall_b);

  // interrupt requests are one-cycle pulses, gated by mask
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_r <= '0;
    end else begin
      irq_r.interval  <= ev_interval & irq_mask.interval;
      irq_r.periodic  <= ev_periodic & irq_mask.periodic;
      irq_r.wrap      <= ev_wrap & irq_mask.wrap;
      irq_r.capture_a <= save_a & irq_mask.capture_a;
      irq_r.capture_b <= save_b & irq_mask.capture_b;
    end
  end
endmodule // frt_capture

/* File: bench/frt_capture_monitor.sv */
// checker on the timer with capture ports
`timescale 1ns/1ps
module frt_capture_monitor (
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic                        capture_input_a,
  input wire logic                        capture_input_b,
  input wire frt_capture_pkg::cap_cfg_t   cap_cfg,
  input wire logic [15:0]                 timer_r,
  input wire frt_capture_pkg::cap_vals_t  cap_vals_r,
  input wire frt_capture_pkg::timer_irq_t irq_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_timer_step: assert property ($past(nrst) |-> timer_r - $past(timer_r) <= 16'h1)
    else $error("timer step");
  a_wrap_at_roll: assert property (irq_r.wrap |-> !timer_r && &$past(timer_r))
    else $error("wrap");
  a_tick_period: assert property (irq_r.periodic |-> !timer_r[9:0] && $changed(timer_r))
    else $error("periodic");
  a_interval_tick: assert property (irq_r.interval |-> $changed(timer_r))
    else $error("interval");
  a_cap_cause: assert property (irq_r.capture_a |-> $past(capture_input_a, 2) != $past(capture_input_a))
    else $error("capture irq");
  a_rise_slice: assert property (
    irq_r.capture_a && !cap_cfg.gang_en && $past(capture_input_a)
    |-> cap_vals_r.rise_a == 8'($past(timer_r) >> cap_cfg.slice_sel_a)) else $error("rise");
  a_fall_slice: assert property (
    irq_r.capture_a && !cap_cfg.gang_en && !$past(capture_input_a)
    |-> cap_vals_r.fall_a == 8'($past(timer_r) >> cap_cfg.slice_sel_a)) else $error("fall");
  a_gang_word: assert property (
    irq_r.capture_a && cap_cfg.gang_en && $past(capture_input_a)
    |-> {cap_vals_r.rise_b, cap_vals_r.rise_a} == $past(timer_r)) else $error("gang");
  a_gang_mutes_b: assert property (cap_cfg.gang_en && $past(cap_cfg.gang_en) |-> !irq_r.capture_b)
    else $error("gang b");
endmodule // frt_capture_monitor

/* File: bench/edge_source.sv */
// edge source standing in for the two capture pins
`timescale 1ns/1ps
module edge_source (
  input  wire logic clk,
  output logic      capture_input_a = 1'b0,
  output logic      capture_input_b = 1'b0
);
  task automatic flip(input logic ch);
    @(posedge clk);
    if (ch) capture_input_b <= !capture_input_b;
    else capture_input_a <= !capture_input_a;
  endtask
endmodule // edge_source

/* File: bench/frt_capture_tb.sv */
// self-checking bench for the timer with capture
`timescale 1ns/1ps
module frt_capture_tb;
  logic                        clk = 1'b0, nrst = 1'b0, pa, pb;
  logic [15:0]                 interval = 16'h0002, t, timer_r;
  frt_capture_pkg::cap_cfg_t   cap_cfg = '{4'h4, 4'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  frt_capture_pkg::timer_irq_t irq_mask = 5'h1F, irq_r;
  frt_capture_pkg::cap_vals_t  cap_vals_r;
  int                          fail_count = 0, checks_done = 0, cyc = 0, n;
  edge_source u_src (.clk(clk), .capture_input_a(pa), .capture_input_b(pb));
  frt_capture u_dut (.clk(clk), .nrst(nrst), .capture_input_a(pa), .capture_input_b(pb),
    .interval(interval), .cap_cfg(cap_cfg), .irq_mask(irq_mask), .timer_r(timer_r),
    .cap_vals_r(cap_vals_r), .irq_r(irq_r));
  initial forever #2 clk = !clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // toggle one pin, note the timer the edge sees, land on the capture cycle
  task automatic edge_cap(input logic ch);
    repeat (300) @(posedge clk);
    u_src.flip(ch);
    #1 t = timer_r;
    @(posedge clk) #1;
  endtask
  task automatic t_count();
    #1 t = timer_r;
    repeat (250) @(posedge clk);
    #1 chk(timer_r - t, 16'h1);
    chk(16'({irq_r.periodic, irq_r.wrap}), 16'h0000);
    $display("t_count done");
  endtask
  task automatic t_slices();
    edge_cap(1'b0);
    chk({cap_vals_r.rise_a, 8'(irq_r.capture_a)}, {8'(t >> 4), 8'h01});
    n = cap_vals_r.rise_a;
    edge_cap(1'b0);
    chk({cap_vals_r.fall_a, cap_vals_r.rise_a}, {8'(t >> 4), 8'(n)});
    edge_cap(1'b1);
    chk({cap_vals_r.rise_b, 8'(irq_r.capture_b)}, {8'(t >> 1), 8'h01});
    $display("t_slices done");
  endtask
  task automatic t_gang();
    @(posedge clk);
    cap_cfg.gang_en <= 1'b1;
    edge_cap(1'b1);
    chk({cap_vals_r.fall_b, 8'(irq_r.capture_b)}, 16'h0000);
    edge_cap(1'b0);
    chk({cap_vals_r.rise_b, cap_vals_r.rise_a}, t);
    $display("t_gang done");
  endtask
  task automatic t_interval();
    for (n = 0; n < 2000 && irq_r.interval !== 1'b1; n++) @(posedge clk) #1;
    @(posedge clk) #1;
    for (n = 1; n < 2000 && irq_r.interval !== 1'b1; n++) @(posedge clk) #1;
    chk(16'(n), 16'(2 * frt_capture_pkg::US_CYCLES));
    $display("t_interval done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_count();
    t_slices();
    t_gang();
    t_interval();
    results();
  end
endmodule // frt_capture_tb
bind frt_capture frt_capture_monitor u_mon (.*);
